// *** src/cit_core_timing.sv ***
// Instruction sequencer: fetch, cycle timing, program counter and external-move routing.
`timescale 1ns/1ns
module cit_core_timing
	import cit_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] code_byte,
	input wire logic [7:0] index_reg_val,
	input wire logic [15:0] data_pointer_16,
	input wire logic [7:0] acc_val,
	input wire logic flash_write_en,
	input wire logic flow_change,
	input wire logic [15:0] flow_target,
	output logic [15:0] pc_q,
	output logic [7:0] opcode_q,
	output logic instr_start_q,
	output logic instr_done_q,
	output logic [3:0] cycles_q,
	output logic [1:0] length_q,
	output logic sfr_select_q,
	output logic upper_ram_select_q,
	output cit_xreq_t xreq_q,
	output logic unknown_op_q
);

	typedef enum logic [1:0] {ST_FETCH, ST_EXEC} cit_state_t;

	cit_decode_t dec;
	cit_state_t state_q, state_d;
	logic [15:0] pc_d;
	logic [7:0] opcode_d;
	logic [7:0] operand_q, operand_d;
	logic [3:0] count_q, count_d;
	logic [3:0] cycles_d;
	logic [1:0] length_d;
	logic start_d, done_d;
	logic sfr_d, upper_d, unknown_d;
	cit_xreq_t xreq_d;
	cit_decode_t dec_q, dec_d;

	// Target choice for the external request: flash, on-chip RAM or off-chip.
	function automatic cit_xtarget_t pick_target(input logic write, input logic fl_en, input logic [15:0] addr);
		cit_xtarget_t t;
		t = XT_OFFCHIP;
		if (write && fl_en)
			t = XT_FLASH;
		else if (addr <= EXTERNAL_RAM_SPACE_ONCHIP_TOP)
			t = XT_ONCHIP_RAM;
		return t;
	endfunction : pick_target

	cit_decode u_decode (
		.opcode(code_byte),
		.dec(dec)
	);

	always_comb
	begin
		state_d = state_q;
		pc_d = pc_q;
		opcode_d = opcode_q;
		operand_d = operand_q;
		count_d = count_q;
		cycles_d = cycles_q;
		length_d = length_q;
		dec_d = dec_q;
		start_d = 1'b0;
		done_d = 1'b0;
		sfr_d = sfr_select_q;
		upper_d = upper_ram_select_q;
		unknown_d = unknown_op_q;
		xreq_d = xreq_q;
		xreq_d.valid = 1'b0;
		unique case (state_q)
			ST_FETCH:
			begin
				opcode_d = code_byte;
				dec_d = dec;
				cycles_d = dec.cycles;
				length_d = dec.length;
				unknown_d = ~dec.known;
				start_d = 1'b1;
				count_d = CYC_ONE;
				if (dec.cycles == CYC_ONE)
				begin
					done_d = 1'b1;
					pc_d = flow_change ? flow_target : pc_q + 16'(dec.length);
				end
				else
				begin
					state_d = ST_EXEC;
					pc_d = pc_q + 16'h0001;
				end
			end
			ST_EXEC:
			begin
				count_d = count_q + CYC_ONE;
				// Operand bytes arrive one per cycle while the pipeline consumes them.
				if (count_q < 4'(dec_q.length))
				begin
					pc_d = pc_q + 16'h0001;
					if (count_q == CYC_ONE)
						operand_d = code_byte;
				end
				if (count_q == CYC_ONE)
				begin
					// Direct at or above DIRECT_SFR_BASE is function space.
					sfr_d = (dec_q.amode == AM_DIRECT) && (code_byte >= DIRECT_SFR_BASE);
					upper_d = (dec_q.amode == AM_INDIRECT) && (index_reg_val >= DIRECT_SFR_BASE);
					if (dec_q.is_xmove)
					begin
						xreq_d.valid = 1'b1;
						xreq_d.write = dec_q.xwrite;
						xreq_d.addr = (dec_q.amode == AM_DATA_POINTER_16) ? data_pointer_16 : {8'h00, index_reg_val};
						xreq_d.wdata = acc_val;
						xreq_d.target = pick_target(dec_q.xwrite, flash_write_en, xreq_d.addr);
					end
					else if (dec_q.is_cmove)
					begin
						xreq_d.valid = 1'b1;
						xreq_d.write = 1'b0;
						xreq_d.target = XT_FLASH;
						xreq_d.addr = 16'(acc_val) + ((dec_q.amode == AM_DATA_POINTER_16) ? data_pointer_16 : pc_q);
						xreq_d.wdata = 8'h00;
					end
				end
				if (count_q + CYC_ONE == cycles_q)
				begin
					done_d = 1'b1;
					state_d = ST_FETCH;
					if (flow_change)
						pc_d = flow_target;
				end
			end
			default:
			begin
				state_d = ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= ST_FETCH;
			pc_q <= PC_RESET;
			opcode_q <= 8'h00;
			operand_q <= 8'h00;
			count_q <= 4'h0;
			cycles_q <= 4'h0;
			length_q <= 2'h0;
			dec_q <= '0;
			instr_start_q <= 1'b0;
			instr_done_q <= 1'b0;
			sfr_select_q <= 1'b0;
			upper_ram_select_q <= 1'b0;
			unknown_op_q <= 1'b0;
			xreq_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			pc_q <= pc_d;
			opcode_q <= opcode_d;
			operand_q <= operand_d;
			count_q <= count_d;
			cycles_q <= cycles_d;
			length_q <= length_d;
			dec_q <= dec_d;
			instr_start_q <= start_d;
			instr_done_q <= done_d;
			sfr_select_q <= sfr_d;
			upper_ram_select_q <= upper_d;
			unknown_op_q <= unknown_d;
			xreq_q <= xreq_d;
		end
	end

endmodule : cit_core_timing

// *** inc/cit_pkg.sv ***
// Package with opcode classes, timing constants and carrier structs of the instruction timing block.
package cit_pkg;

	localparam int CLK_MHZ = 125;
	localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_TWO = 4'h2;
	localparam logic [3:0] CYC_THREE = 4'h3;
	localparam logic [3:0] CYC_FOUR = 4'h4;
	localparam logic [3:0] CYC_EIGHT = 4'h8;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// Opcode values decoded individually, among them the external-move and code-move groups.
	localparam logic [7:0] OP_XMOV_RD_IDX0 = 8'he2;
	localparam logic [7:0] OP_XMOV_RD_IDX1 = 8'he3;
	localparam logic [7:0] OP_XMOV_WR_IDX0 = 8'hf2;
	localparam logic [7:0] OP_XMOV_WR_IDX1 = 8'hf3;
	localparam logic [7:0] OP_XMOV_RD_DP = 8'he0;
	localparam logic [7:0] OP_XMOV_WR_DP = 8'hf0;
	localparam logic [7:0] OP_CMOV_DP = 8'h93;
	localparam logic [7:0] OP_CMOV_PC = 8'h83;
	localparam logic [7:0] OP_LOAD_DP = 8'h90;
	localparam logic [7:0] OP_PUSH = 8'hc0;
	localparam logic [7:0] OP_POP = 8'hd0;
	localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_LOW_NIB_0 = 8'hd6;
	localparam logic [7:0] OP_LOW_NIB_1 = 8'hd7;
	localparam logic [7:0] OP_MUL = 8'ha4;
	localparam logic [7:0] OP_DIV = 8'h84;
	localparam logic [7:0] OP_RR = 8'h03;
	localparam logic [7:0] OP_RRC = 8'h13;
	localparam logic [7:0] OP_RL = 8'h23;
	localparam logic [7:0] OP_RLC = 8'h33;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_NOP_ALT = 8'ha5;
	localparam logic [7:0] OP_MOV_DIR_IND0 = 8'h86;
	localparam logic [7:0] OP_MOV_DIR_IND1 = 8'h87;
	localparam logic [7:0] OP_MOV_IND_IMM0 = 8'h76;
	localparam logic [7:0] OP_MOV_IND_IMM1 = 8'h77;
	localparam logic [15:0] EXTERNAL_RAM_SPACE_ONCHIP_TOP = 16'h0fff;

	typedef enum logic [1:0] {XT_NONE, XT_ONCHIP_RAM, XT_OFFCHIP, XT_FLASH} cit_xtarget_t;

	typedef enum logic [2:0] {AM_NONE, AM_BANK, AM_DIRECT, AM_INDIRECT, AM_IMMED, AM_DATA_POINTER_16, AM_PCREL} cit_amode_t;

	typedef struct packed {
		logic [1:0] length;
		logic [3:0] cycles;
		cit_amode_t amode;
		logic is_xmove;
		logic is_cmove;
		logic xwrite;
		logic known;
	} cit_decode_t;

	typedef struct packed {
		logic valid;
		logic write;
		cit_xtarget_t target;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cit_xreq_t;

endpackage : cit_pkg

// *** src/cit_decode.sv ***
// Combinational opcode decoder giving length, cycles and addressing mode.
`timescale 1ns/1ns
module cit_decode
	import cit_pkg::*;
(
	input wire logic [7:0] opcode,
	output cit_decode_t dec
);

	always_comb
	begin
		dec = '{length: LEN_ONE, cycles: CYC_ONE, amode: AM_NONE, is_xmove: 1'b0, is_cmove: 1'b0,
			xwrite: 1'b0, known: 1'b1};
		if (opcode[7:4] inside {4'h2, 4'h3, 4'h9} && opcode[3])
			dec.amode = AM_BANK;
		else if (opcode[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6} && opcode[3:0] == 4'h5)
		begin
			dec.length = LEN_TWO;
			dec.cycles = CYC_TWO;
			dec.amode = AM_DIRECT;
		end
		else if (opcode[7:4] inside {4'h2, 4'h3, 4'h9} && opcode[3:1] == 3'h3)
		begin
			dec.cycles = CYC_TWO;
			dec.amode = AM_INDIRECT;
		end
		else if (opcode[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6} && opcode[3:0] == 4'h4)
		begin
			dec.length = LEN_TWO;
			dec.cycles = CYC_TWO;
			dec.amode = AM_IMMED;
		end
		else if (opcode[7:4] inside {4'h4, 4'h5, 4'h6} && opcode[3:0] == 4'h2)
		begin
			dec.length = LEN_TWO;
			dec.cycles = CYC_TWO;
			dec.amode = AM_DIRECT;
		end
		else if (opcode[7:4] inside {4'h4, 4'h5, 4'h6} && opcode[3:0] == 4'h3)
		begin
			dec.length = LEN_THREE;
			dec.cycles = CYC_THREE;
			dec.amode = AM_DIRECT;
		end
		else if (opcode[7:4] inside {4'h4, 4'h5, 4'h6} && opcode[3:1] == 3'h3)
		begin
			dec.cycles = CYC_TWO;
			dec.amode = AM_INDIRECT;
		end
		else if (opcode[7:4] == 4'hc && opcode[3])
			dec.amode = AM_BANK;
		else
		begin
			unique case (opcode)
				OP_RR, OP_RRC, OP_RL, OP_RLC, OP_NOP, OP_NOP_ALT:
				begin
					dec.cycles = CYC_ONE;
				end
				OP_XMOV_RD_IDX0, OP_XMOV_RD_IDX1, OP_XMOV_WR_IDX0, OP_XMOV_WR_IDX1:
				begin
					dec.cycles = CYC_THREE;
					dec.amode = AM_INDIRECT;
					dec.is_xmove = 1'b1;
					dec.xwrite = opcode[4];
				end
				OP_XMOV_RD_DP, OP_XMOV_WR_DP:
				begin
					dec.cycles = CYC_THREE;
					dec.amode = AM_DATA_POINTER_16;
					dec.is_xmove = 1'b1;
					dec.xwrite = opcode[4];
				end
				OP_CMOV_DP, OP_CMOV_PC:
				begin
					dec.cycles = CYC_THREE;
					dec.amode = (opcode == OP_CMOV_DP) ? AM_DATA_POINTER_16 : AM_PCREL;
					dec.is_cmove = 1'b1;
				end
				OP_MOV_DIR_DIR:
				begin
					dec.length = LEN_THREE;
					dec.cycles = CYC_THREE;
					dec.amode = AM_DIRECT;
				end
				OP_LOAD_DP:
				begin
					dec.length = LEN_THREE;
					dec.cycles = CYC_THREE;
					dec.amode = AM_IMMED;
				end
				OP_PUSH, OP_POP:
				begin
					dec.length = LEN_TWO;
					dec.cycles = CYC_TWO;
					dec.amode = AM_DIRECT;
				end
				OP_LOW_NIB_0, OP_LOW_NIB_1:
				begin
					dec.cycles = CYC_TWO;
					dec.amode = AM_INDIRECT;
				end
				OP_MOV_DIR_IND0, OP_MOV_DIR_IND1:
				begin
					dec.length = LEN_TWO;
					dec.cycles = CYC_TWO;
					dec.amode = AM_INDIRECT;
				end
				OP_MOV_IND_IMM0, OP_MOV_IND_IMM1:
				begin
					dec.length = LEN_TWO;
					dec.cycles = CYC_TWO;
					dec.amode = AM_INDIRECT;
				end
				OP_MUL:
				begin
					dec.cycles = CYC_FOUR;
				end
				OP_DIV:
				begin
					dec.cycles = CYC_EIGHT;
				end
				// Opcodes outside the covered groups are timed as one byte, one cycle.
				default:
				begin
					dec.known = 1'b0;
				end
			endcase
		end
	end

endmodule : cit_decode

// *** verification/cit_core_timing_sva.sv ***
// Timing checker for the instruction sequencer ports.
`timescale 1ns/1ns
module cit_core_timing_sva
	import cit_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] opcode_q,
	input wire logic instr_start_q,
	input wire logic instr_done_q,
	input wire logic [3:0] cycles_q,
	input wire logic [1:0] length_q,
	input wire cit_xreq_t xreq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire st = instr_start_q;
	AST_ONE: assert property (st && cycles_q == CYC_ONE |-> instr_done_q) else $error("one cycle");
	AST_TWO: assert property (st && cycles_q == CYC_TWO |-> !instr_done_q ##1 instr_done_q) else $error("two");
	AST_THREE: assert property (st && cycles_q == CYC_THREE |-> !instr_done_q[*2] ##1 instr_done_q) else $error("three");
	AST_NEXT: assert property (instr_done_q |=> st) else $error("next start late");
	AST_XIDX: assert property (st && opcode_q[7:5] == 3'h7 && opcode_q[3:1] == 3'h1
		|-> length_q == LEN_ONE && cycles_q == CYC_THREE ##1 xreq_q.valid) else $error("index move");
	AST_XDP: assert property (st && opcode_q[7:5] == 3'h7 && opcode_q[3:0] == 4'h0
		|-> cycles_q == CYC_THREE ##1 xreq_q.valid && xreq_q.write == opcode_q[4]) else $error("pointer move");
	AST_CMOV: assert property (st && (opcode_q == OP_CMOV_DP || opcode_q == OP_CMOV_PC)
		|-> length_q == LEN_ONE ##1 xreq_q.valid && xreq_q.target == XT_FLASH) else $error("code move");
	AST_ROT: assert property (st && opcode_q[7:6] == 2'h0 && opcode_q[3:0] == 4'h3
		|-> length_q == LEN_ONE && cycles_q == CYC_ONE) else $error("rotate");
	AST_DPLD: assert property (st && opcode_q == OP_LOAD_DP |-> length_q == LEN_THREE) else $error("load");
	AST_TGT: assert property (xreq_q.valid |-> xreq_q.target != XT_NONE) else $error("no target");
endmodule : cit_core_timing_sva
bind cit_core_timing cit_core_timing_sva chk_i (.clk(clk), .sys_rst(sys_rst), .opcode_q(opcode_q),
	.instr_start_q(instr_start_q), .instr_done_q(instr_done_q), .cycles_q(cycles_q), .length_q(length_q), .xreq_q(xreq_q));

// *** verification/cit_code_mem.sv ***
// Program memory model answering fetches at the program counter.
`timescale 1ns/1ns
module cit_code_mem
	import cit_pkg::*;
(
	input wire logic [15:0] pc_q,
	output logic [7:0] code_byte
);
	logic [7:0] mem [0:255];
	assign code_byte = mem[pc_q[7:0]];
endmodule : cit_code_mem

// *** verification/testbench.sv ***
// Self-checking bench of the instruction sequencer.
`timescale 1ns/1ns
module testbench
	import cit_pkg::*;
;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic flash_write_en = 1'h0;
	logic flow_change = 1'h0;
	logic [7:0] idx = 8'h40;
	logic [7:0] acc = 8'h5a;
	logic [15:0] dp = 16'h1234;
	logic [7:0] code_byte, opcode_q;
	logic [15:0] pc_q, a;
	logic instr_start_q, instr_done_q, sfr_select_q, upper_ram_select_q, unknown_op_q;
	logic [3:0] cycles_q;
	logic [1:0] length_q;
	cit_xreq_t xreq_q;
	int n_errors = 0;
	int checks = 0;
	int tick = 0;
	int t0;
	logic [19:0] rows [38] = '{20'h28110, 20'h39110, 20'h9a110, 20'h25220, 20'h35220, 20'h95220, 20'h26120,
		20'h24220, 20'h53330, 20'h43330, 20'h63330, 20'h52220, 20'h62220, 20'h57120, 20'h66120, 20'h23110,
		20'h33110, 20'h03110, 20'h13110, 20'h85330, 20'h90330, 20'hc0220, 20'hd0220, 20'hcb110, 20'hd6120,
		20'h86220, 20'h76220, 20'he2130, 20'he3130, 20'hf2130, 20'hf3130, 20'he0130, 20'hf0130, 20'h93130,
		20'h83130, 20'ha4140, 20'h84180, 20'h02111};
	cit_core_timing uut (.clk(clk), .sys_rst(sys_rst), .code_byte(code_byte), .index_reg_val(idx),
		.data_pointer_16(dp), .acc_val(acc), .flash_write_en(flash_write_en), .flow_change(flow_change),
		.flow_target(16'h0040), .pc_q(pc_q), .opcode_q(opcode_q), .instr_start_q(instr_start_q),
		.instr_done_q(instr_done_q), .cycles_q(cycles_q), .length_q(length_q), .sfr_select_q(sfr_select_q),
		.upper_ram_select_q(upper_ram_select_q), .xreq_q(xreq_q), .unknown_op_q(unknown_op_q));
	cit_code_mem mem_i (.pc_q(pc_q), .code_byte(code_byte));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// Inputs move one nanosecond after the edge so no race with the design.
	task automatic tk;
		@(posedge clk);
		#1;
	endtask : tk
	task automatic wait_start;
		int k;
		k = 0;
		tk();
		while (instr_start_q !== 1'h1 && k < 20)
		begin
			tk();
			k++;
		end
		if (instr_start_q !== 1'h1)
		begin
			n_errors++;
			complete_run();
		end
	endtask : wait_start
	task automatic restart;
		sys_rst = 1'h1;
		repeat (16) tk();
		chk(pc_q, 32'h0);
		chk(instr_start_q, 32'h0);
		sys_rst = 1'h0;
	endtask : restart
	initial
	begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) tick <= tick + 1;
	initial
	begin
		#200000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		a = 16'h0;
		for (int j = 0; j < 256; j++) mem_i.mem[j] = 8'h00;
		foreach (rows[i])
		begin
			mem_i.mem[a] = rows[i][19:12];
			a += rows[i][11:8];
		end
		restart();
		a = 16'h0;
		foreach (rows[i])
		begin
			wait_start();
			if (i > 0)
				chk(tick - t0, rows[i - 1][7:4]);
			t0 = tick;
			chk({opcode_q, 2'h0, length_q, cycles_q, 3'h0, unknown_op_q}, rows[i]);
			if (rows[i][19:16] >= 4'he || rows[i][15:12] == 4'h3 && rows[i][19:16] != 4'h2 && rows[i][19] == 1'h1)
			begin
				tk();
				if (rows[i][19:16] >= 4'he)
					chk(xreq_q[27:8], {2'h2 | rows[i][16], rows[i][13] ? XT_ONCHIP_RAM : XT_OFFCHIP,
						rows[i][13] ? 16'h0040 : dp});
				else
					chk(xreq_q[27:8], {2'h2, XT_FLASH, 16'(acc) + (rows[i][16] ? dp : a + 16'h0001)});
			end
			a += 16'(rows[i][11:8]);
		end
		wait_start();
		chk(tick - t0, 32'h1);
		for (int j = 0; j < 256; j++) mem_i.mem[j] = 8'h00;
		for (int j = 0; j < 8; j++) mem_i.mem[j] = 8'(64'h257f258026f0e024 >> (56 - 8 * j));
		mem_i.mem[8'h40] = OP_RL;
		idx = 8'h80;
		dp = 16'h0800;
		acc = 8'h3c;
		flash_write_en = 1'h1;
		restart();
		for (int j = 0; j < 3; j++)
		begin
			wait_start();
			tk();
			chk({sfr_select_q, upper_ram_select_q}, j == 0 ? 32'h0 : j == 1 ? 32'h2 : 32'h1);
		end
		wait_start();
		tk();
		chk(xreq_q, {2'h3, XT_FLASH, 16'h0800, 8'h3c});
		wait_start();
		tk();
		chk(xreq_q[27:24], {2'h2, XT_ONCHIP_RAM});
		wait_start();
		flow_change = 1'h1;
		tk();
		flow_change = 1'h0;
		chk(instr_done_q, 32'h1);
		chk(pc_q, 32'h40);
		wait_start();
		chk(opcode_q, OP_RL);
		chk(pc_q, 32'h41);
		complete_run();
	end
endmodule : testbench
